// ===== rtl/ext_bus_ctrl.sv
// External bus controller: latch strobe, wait request, hold hand-over and bus clock output.
// Behaviour
// - Latch strobe routed to pin by select bits.
// - Latch strobe pulses on internal accesses too.
// - Low wait sample on last clock stretches external cycles.
// - High wait sample resumes the stalled cycle.
// - Pins frozen while waiting; peripherals run.
// - Wait ignored just before software waits.
// - Finish current access before entering hold.
// - Stay in hold, grant low, while requested.
// - Priority: external request, DMA, then CPU.
// - Hold floats strobes, address, data, selects, enable.
// - Hold keeps ports, drives latch strobe low.
// - Hold stops watchdog, CPU and DMA grants; other peripherals keep running.
// - Internal access keeps address, floats data.
// - Internal access keeps upper byte enable.
// - Internal access: strobes, selects high; latch toggles.
// - Bus clock out only when selects are zero.
// - No bus clock in single-chip mode.
`timescale 1ns/1ps
`include "ext_bus_regs.svh"
module ext_bus_ctrl #(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 16,
    parameter int CS_W = 4,
    parameter int PORT_W = 8,
    parameter int SOFT_WAIT_W = 4
) (
    input wire logic REF_CLK,
    input wire logic RSTN,
    // Bus clock from the clock generator, sampled here.
    input wire logic BUS_CLK,
    input wire logic WAIT_REQ_N,
    input wire logic BUS_REQ_N,
    // Requests from the two internal masters.
    input wire logic CPU_REQ,
    input wire logic CPU_WRITE,
    input wire logic CPU_INTERNAL,
    input wire logic [ADDR_W-1:0] CPU_ADDR,
    input wire logic [DATA_W-1:0] CPU_WDATA,
    input wire logic [CS_W-1:0] CPU_CS,
    input wire logic [1:0] CPU_BYTE_EN,
    input wire logic DMA_REQ,
    input wire logic DMA_WRITE,
    input wire logic DMA_INTERNAL,
    input wire logic [ADDR_W-1:0] DMA_ADDR,
    input wire logic [DATA_W-1:0] DMA_WDATA,
    input wire logic [CS_W-1:0] DMA_CS,
    input wire logic [1:0] DMA_BYTE_EN,
    input wire logic [SOFT_WAIT_W-1:0] SOFT_WAITS,
    input wire logic [PORT_W-1:0] PORT_OUT_NEXT,
    input wire logic LATCH_PIN_SELECT_HI,
    input wire logic LATCH_PIN_SELECT_LO,
    input wire logic CLOCK_PIN_OUTPUT_SELECT,
    input wire logic CLOCK_OUT_FUNCTION_HI,
    input wire logic CLOCK_OUT_FUNCTION_LO,
    input wire logic SINGLE_CHIP_MODE,
    input wire logic [DATA_W-1:0] DATA_IN,
    output logic CPU_GRANT,
    output logic DMA_GRANT,
    output logic CYCLE_DONE,
    output logic [DATA_W-1:0] READ_DATA,
    output logic WATCHDOG_RUN,
    output logic HOLD_GRANT_N,
    output logic READ_STROBE_N,
    output logic READ_STROBE_OE_N,
    output logic LOW_BYTE_STORE_STROBE_N,
    output logic HIGH_BYTE_STORE_STROBE_N,
    output logic STORE_STROBE_OE_N,
    output logic UPPER_BYTE_ENABLE_N,
    output logic UPPER_BYTE_ENABLE_OE_N,
    output logic [ADDR_W-1:0] ADDR_OUT,
    output logic ADDR_OE_N,
    output logic [DATA_W-1:0] DATA_OUT,
    output logic DATA_OE_N,
    output logic [CS_W-1:0] CHIP_SELECT_N,
    output logic CHIP_SELECT_OE_N,
    output logic [2:0] LATCH_STROBE_PINS,
    output logic [PORT_W-1:0] PORT_PINS,
    output logic CLOCK_OUT_PIN,
    output logic CLOCK_OUT_PIN_EN
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        ext_bus_pkg::bus_state_type st;
        ext_bus_pkg::grant_type owner;
        logic bclk_prev;
        logic wr;
        logic internal;
        logic [SOFT_WAIT_W-1:0] waits;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [CS_W-1:0] cs_n;
        logic [1:0] be;
        logic ube_n;
        logic rd_n;
        logic wrl_n;
        logic wrh_n;
        logic ale;
        logic data_oe_n;
        logic float_n;
        logic hold_n;
        logic [PORT_W-1:0] port;
        logic done;
        logic [DATA_W-1:0] rdata;
        logic clk_out;
    } ctrl_state_type;

    ctrl_state_type s_q;
    ctrl_state_type s_d;

    logic bclk_s;
    logic wait_n_s;
    logic breq_n_s;
    logic [DATA_W-1:0] din_s;

    // ----------------------------------------------------------------
    // Synchronisers
    // ----------------------------------------------------------------
    // The data word is settled for a whole bus clock before it is captured.
    // A plain two flip-flop pass is therefore safe for it, even without a handshake.
    pin_sync #(
        .WIDTH(3 + DATA_W),
        .RESET_VALUE({3'h3, {DATA_W{1'b0}}})
    ) u_sync (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .d({BUS_CLK, WAIT_REQ_N, BUS_REQ_N, DATA_IN}),
        .q({bclk_s, wait_n_s, breq_n_s, din_s})
    );

    logic bclk_rise;
    logic bclk_fall;
    assign bclk_rise = bclk_s && !s_q.bclk_prev;
    assign bclk_fall = !bclk_s && s_q.bclk_prev;

    // ----------------------------------------------------------------
    // Arbitration
    // ----------------------------------------------------------------
    function automatic ext_bus_pkg::grant_type pick(input logic hold_rq, input logic dma_rq, input logic cpu_rq);
        ext_bus_pkg::grant_type g;
        g = ext_bus_pkg::GRANT_NONE;
        if (hold_rq) begin
            g = ext_bus_pkg::GRANT_HOLD;
        end else if (dma_rq) begin
            g = ext_bus_pkg::GRANT_DMA;
        end else if (cpu_rq) begin
            g = ext_bus_pkg::GRANT_CPU;
        end
        return g;
    endfunction

    ext_bus_pkg::grant_type next_owner;
    assign next_owner = pick(!breq_n_s, DMA_REQ, CPU_REQ);

    // ----------------------------------------------------------------
    // Bus cycle sequencer
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.bclk_prev = bclk_s;
        s_d.done = 1'b0;
        s_d.clk_out = bclk_s;
        case (s_q.st)
            ext_bus_pkg::ST_IDLE: begin
                s_d.port = PORT_OUT_NEXT;
                s_d.ale = 1'b0;
                if (bclk_rise) begin
                    s_d.owner = next_owner;
                    if (next_owner == ext_bus_pkg::GRANT_HOLD) begin
                        s_d.st = ext_bus_pkg::ST_HOLD;
                        s_d.float_n = 1'b1;
                        s_d.hold_n = 1'b0;
                        s_d.data_oe_n = 1'b1;
                        s_d.ale = 1'b0;
                    end else if (next_owner != ext_bus_pkg::GRANT_NONE) begin
                        s_d.st = ext_bus_pkg::ST_ACCESS;
                        s_d.ale = 1'b1;
                        if (next_owner == ext_bus_pkg::GRANT_DMA) begin
                            s_d.wr = DMA_WRITE;
                            s_d.internal = DMA_INTERNAL;
                            s_d.wdata = DMA_WDATA;
                            s_d.be = DMA_BYTE_EN;
                            if (!DMA_INTERNAL) begin
                                s_d.addr = DMA_ADDR;
                                s_d.cs_n = ~DMA_CS;
                            end
                        end else begin
                            s_d.wr = CPU_WRITE;
                            s_d.internal = CPU_INTERNAL;
                            s_d.wdata = CPU_WDATA;
                            s_d.be = CPU_BYTE_EN;
                            if (!CPU_INTERNAL) begin
                                s_d.addr = CPU_ADDR;
                                s_d.cs_n = ~CPU_CS;
                            end
                        end
                        s_d.waits = SOFT_WAITS;
                    end
                end
            end
            ext_bus_pkg::ST_ACCESS: begin
                if (bclk_fall) begin
                    s_d.ale = 1'b0;
                    if (s_q.internal) begin
                        s_d.cs_n = {CS_W{1'b1}};
                        s_d.data_oe_n = 1'b1;
                    end else begin
                        s_d.ube_n = !s_q.be[1];
                        s_d.rd_n = s_q.wr;
                        s_d.wrl_n = !(s_q.wr && s_q.be[0]);
                        s_d.wrh_n = !(s_q.wr && s_q.be[1]);
                        s_d.data_oe_n = !s_q.wr;
                    end
                    // The wait request is not looked at here, so a request that arrives just
                    // ahead of the software waits has no effect.
                    s_d.st = (s_q.waits != '0) ? ext_bus_pkg::ST_SOFT_WAIT : ext_bus_pkg::ST_LAST;
                end
            end
            ext_bus_pkg::ST_SOFT_WAIT: begin
                if (bclk_fall) begin
                    s_d.waits = s_q.waits - 1'b1;
                    if (s_q.waits == {{(SOFT_WAIT_W-1){1'b0}}, 1'b1}) begin
                        s_d.st = ext_bus_pkg::ST_LAST;
                    end
                end
            end
            ext_bus_pkg::ST_LAST, ext_bus_pkg::ST_READY_WAIT: begin
                // Outputs are left untouched while stretched, so pins hold their state.
                if (bclk_fall) begin
                    if (!s_q.internal && !wait_n_s) begin
                        s_d.st = ext_bus_pkg::ST_READY_WAIT;
                    end else begin
                        s_d.st = ext_bus_pkg::ST_IDLE;
                        s_d.done = 1'b1;
                        s_d.rdata = din_s;
                        s_d.rd_n = 1'b1;
                        s_d.wrl_n = 1'b1;
                        s_d.wrh_n = 1'b1;
                        s_d.data_oe_n = 1'b1;
                        s_d.owner = ext_bus_pkg::GRANT_NONE;
                    end
                end
            end
            ext_bus_pkg::ST_HOLD: begin
                if (breq_n_s) begin
                    s_d.st = ext_bus_pkg::ST_IDLE;
                    s_d.hold_n = 1'b1;
                    s_d.float_n = 1'b0;
                    s_d.owner = ext_bus_pkg::GRANT_NONE;
                end
            end
            default: begin
                s_d.st = ext_bus_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            s_q <= '{
                st: ext_bus_pkg::ST_IDLE,
                owner: ext_bus_pkg::GRANT_NONE,
                // Matches the synchroniser's reset level, so no false edge follows reset.
                bclk_prev: 1'b0,
                wr: 1'b0,
                internal: 1'b0,
                waits: '0,
                addr: `ADDR_RESET,
                wdata: `DATA_RESET,
                cs_n: '1,
                be: 2'h0,
                ube_n: 1'b1,
                rd_n: 1'b1,
                wrl_n: 1'b1,
                wrh_n: 1'b1,
                ale: 1'b0,
                data_oe_n: 1'b1,
                float_n: 1'b0,
                hold_n: 1'b1,
                port: '0,
                done: 1'b0,
                rdata: `DATA_RESET,
                clk_out: 1'b0
            };
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    logic clk_enable;
    // The clock gate uses the synchronised bus clock, so the pin lags by three reference clocks.
    assign clk_enable = !CLOCK_PIN_OUTPUT_SELECT && !SINGLE_CHIP_MODE &&
        ({CLOCK_OUT_FUNCTION_HI, CLOCK_OUT_FUNCTION_LO} == `CLK_FUNC_PORT);

    // Select code zero leaves every strobe pin free for port use.
    function automatic logic [2:0] latch_onehot(input logic [1:0] code);
        logic [2:0] hit;
        hit = 3'h0;
        if (code == `LATCH_SEL_PIN_A) begin
            hit = 3'h1;
        end else if (code == `LATCH_SEL_PIN_B) begin
            hit = 3'h2;
        end else if (code == `LATCH_SEL_PIN_C) begin
            hit = 3'h4;
        end
        return hit;
    endfunction

    logic [1:0] latch_sel;
    logic [2:0] latch_hit;
    assign latch_sel = {LATCH_PIN_SELECT_HI, LATCH_PIN_SELECT_LO};
    assign latch_hit = latch_onehot(latch_sel);

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_latch
            assign LATCH_STROBE_PINS[gi] = s_q.ale && latch_hit[gi];
        end
    endgenerate

    assign CPU_GRANT = (s_q.owner == ext_bus_pkg::GRANT_CPU);
    assign DMA_GRANT = (s_q.owner == ext_bus_pkg::GRANT_DMA);
    assign CYCLE_DONE = s_q.done;
    assign READ_DATA = s_q.rdata;
    assign WATCHDOG_RUN = s_q.hold_n;
    assign HOLD_GRANT_N = s_q.hold_n;
    assign READ_STROBE_N = s_q.rd_n;
    assign READ_STROBE_OE_N = s_q.float_n;
    assign LOW_BYTE_STORE_STROBE_N = s_q.wrl_n;
    assign HIGH_BYTE_STORE_STROBE_N = s_q.wrh_n;
    assign STORE_STROBE_OE_N = s_q.float_n;
    assign UPPER_BYTE_ENABLE_N = s_q.ube_n;
    assign UPPER_BYTE_ENABLE_OE_N = s_q.float_n;
    assign ADDR_OUT = s_q.addr;
    assign ADDR_OE_N = s_q.float_n;
    assign DATA_OUT = s_q.wdata;
    assign DATA_OE_N = s_q.data_oe_n;
    assign CHIP_SELECT_N = s_q.cs_n;
    assign CHIP_SELECT_OE_N = s_q.float_n;
    assign PORT_PINS = s_q.port;
    assign CLOCK_OUT_PIN = s_q.clk_out && clk_enable;
    assign CLOCK_OUT_PIN_EN = clk_enable;
endmodule

// ===== rtl/ext_bus_regs.svh
// Constants for the external bus wait and hold controller.
`ifndef EXT_BUS_REGS_SVH
`define EXT_BUS_REGS_SVH

`define LATCH_SEL_NONE 2'h0
`define LATCH_SEL_PIN_A 2'h1
`define LATCH_SEL_PIN_B 2'h2
`define LATCH_SEL_PIN_C 2'h3
`define CLK_FUNC_PORT 2'h0
`define ADDR_RESET 24'h000000
`define DATA_RESET 16'h0000

`endif

// ===== rtl/ext_bus_pkg.sv
// Types shared by the external bus controller files.
package ext_bus_pkg;

typedef enum {
    ST_IDLE,
    ST_ACCESS,
    ST_SOFT_WAIT,
    ST_LAST,
    ST_READY_WAIT,
    ST_HOLD
} bus_state_type;

typedef enum logic [1:0] {
    GRANT_NONE,
    GRANT_HOLD,
    GRANT_DMA,
    GRANT_CPU
} grant_type;

endpackage

// ===== rtl/pin_sync.sv
// Two flip-flop synchroniser for inputs from outside the clock domain.
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_type;

    sync_state_type s_q;
    sync_state_type s_d;

    always_comb begin
        s_d = s_q;
        s_d.first = d;
        s_d.second = s_q.first;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= {RESET_VALUE, RESET_VALUE};
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.second;
endmodule

// ===== tb/ext_bus_ctrl_assertions.sv
// Concurrent checks on the external bus controller ports.
`timescale 1ns/1ps
module ext_bus_ctrl_chk #(
    parameter int ADDR_W = 24,
    parameter int CS_W = 4,
    parameter int PORT_W = 8
) (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic LATCH_PIN_SELECT_HI,
    input wire logic LATCH_PIN_SELECT_LO,
    input wire logic CLOCK_PIN_OUTPUT_SELECT,
    input wire logic CLOCK_OUT_FUNCTION_HI,
    input wire logic CLOCK_OUT_FUNCTION_LO,
    input wire logic SINGLE_CHIP_MODE,
    input wire logic CPU_GRANT,
    input wire logic DMA_GRANT,
    input wire logic WATCHDOG_RUN,
    input wire logic HOLD_GRANT_N,
    input wire logic READ_STROBE_N,
    input wire logic READ_STROBE_OE_N,
    input wire logic STORE_STROBE_OE_N,
    input wire logic UPPER_BYTE_ENABLE_OE_N,
    input wire logic [ADDR_W-1:0] ADDR_OUT,
    input wire logic ADDR_OE_N,
    input wire logic DATA_OE_N,
    input wire logic [CS_W-1:0] CHIP_SELECT_N,
    input wire logic CHIP_SELECT_OE_N,
    input wire logic [2:0] LATCH_STROBE_PINS,
    input wire logic [PORT_W-1:0] PORT_PINS,
    input wire logic CLOCK_OUT_PIN,
    input wire logic CLOCK_OUT_PIN_EN
);
    // ----
    // Checks
    // ----
    default clocking @(posedge REF_CLK);
    endclocking
    default disable iff (!RSTN);
    wire hold = !HOLD_GRANT_N;
    wire [1:0] sel = {LATCH_PIN_SELECT_HI, LATCH_PIN_SELECT_LO};
    chk_hold_float: assert property (hold |-> ADDR_OE_N && DATA_OE_N && READ_STROBE_OE_N
        && STORE_STROBE_OE_N && CHIP_SELECT_OE_N && UPPER_BYTE_ENABLE_OE_N) else $error("bus driven in hold");
    chk_hold_latch: assert property (hold && $past(hold) |-> LATCH_STROBE_PINS == 3'h0)
        else $error("latch strobe high in hold");
    chk_hold_ports: assert property (hold && $past(hold) |-> $stable(PORT_PINS))
        else $error("ports moved in hold");
    chk_hold_wdog: assert property (hold && $past(hold) |-> !WATCHDOG_RUN)
        else $error("watchdog runs in hold");
    chk_hold_owner: assert property (hold |-> !CPU_GRANT && !DMA_GRANT)
        else $error("internal master owns bus in hold");
    chk_latch_route: assert property (LATCH_STROBE_PINS != 3'h0 |-> sel != 2'h0
        && LATCH_STROBE_PINS == 3'h1 << (sel - 2'h1)) else $error("latch strobe on wrong pin");
    chk_wait_freeze: assert property (!READ_STROBE_N && $past(!READ_STROBE_N) |-> $stable(ADDR_OUT)
        && $stable(CHIP_SELECT_N)) else $error("address moved during read");
    chk_clk_enable: assert property (CLOCK_OUT_PIN_EN == (!SINGLE_CHIP_MODE && !CLOCK_PIN_OUTPUT_SELECT
        && !CLOCK_OUT_FUNCTION_HI && !CLOCK_OUT_FUNCTION_LO)) else $error("clock enable wrong");
    chk_clk_quiet: assert property (!CLOCK_OUT_PIN_EN && $past(!CLOCK_OUT_PIN_EN) |-> !CLOCK_OUT_PIN)
        else $error("clock out while disabled");
    cov_hold: cover property (hold);
    cov_read: cover property (!READ_STROBE_N);
    cov_clk: cover property (CLOCK_OUT_PIN);
endmodule

bind ext_bus_ctrl ext_bus_ctrl_chk #(.ADDR_W(ADDR_W), .CS_W(CS_W), .PORT_W(PORT_W)) ext_bus_ctrl_chk_inst (.*);

// ===== tb/ext_mem_model.sv
// Behavioural external memory answering the controller's bus cycles.
`timescale 1ns/1ps
module ext_mem_model (
    input wire logic bus_clk,
    input wire logic latch,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [23:0] addr,
    input wire logic [3:0] stretch,
    output logic wait_n,
    output logic [15:0] rdata,
    output logic [23:0] cap
);
    // ----
    // Behaviour
    // ----
    logic [3:0] cnt = 4'h0;
    initial wait_n = 1'b1;
    initial cap = 24'h0;
    // A released data bus shows the inverse of the read value, so a late capture cannot pass.
    assign rdata = rd_n ? ~(addr[15:0] ^ 16'ha5c3) : addr[15:0] ^ 16'ha5c3;
    always @(negedge latch) begin
        cap <= addr;
    end
    // Set up on the rising edge so that the falling-edge sample sees a settled level.
    always @(posedge bus_clk) begin
        if ((!rd_n || !wr_n) && cnt < stretch) begin
            wait_n <= 1'b0;
            cnt <= cnt + 4'h1;
        end else begin
            wait_n <= 1'b1;
            if (rd_n && wr_n) begin
                cnt <= 4'h0;
            end
        end
    end
endmodule

// ===== tb/ext_bus_ctrl_tb.sv
// Self-checking bench for the external bus controller.
`timescale 1ns/1ps
module ext_bus_ctrl_tb;
    logic REF_CLK = 1'b0, RSTN = 1'b0, BUS_CLK = 1'b0, BUS_REQ_N = 1'b1, CPU_REQ = 1'b0, DMA_REQ = 1'b0;
    logic CPU_WRITE = 1'b0, CPU_INTERNAL = 1'b0, LATCH_PIN_SELECT_HI = 1'b0, LATCH_PIN_SELECT_LO = 1'b1;
    logic CLOCK_PIN_OUTPUT_SELECT = 1'b0, CLOCK_OUT_FUNCTION_HI = 1'b0, CLOCK_OUT_FUNCTION_LO = 1'b0;
    logic SINGLE_CHIP_MODE = 1'b0, doe = 1'b0, hseen = 1'b0, clk_hi = 1'b0;
    logic [23:0] CPU_ADDR = 24'h0;
    logic [15:0] CPU_WDATA = 16'h0, wseen = 16'h0;
    logic [3:0] CPU_CS = 4'h2, SOFT_WAITS = 4'h0, stretch = 4'h0;
    logic [1:0] CPU_BYTE_EN = 2'h3;
    logic [7:0] PORT_OUT_NEXT = 8'h3c;
    logic [2:0] seen = 3'h0;
    wire DMA_WRITE = CPU_WRITE, DMA_INTERNAL = CPU_INTERNAL;
    wire [23:0] DMA_ADDR = CPU_ADDR, cap, ADDR_OUT;
    wire [15:0] DMA_WDATA = CPU_WDATA, DATA_IN, READ_DATA, DATA_OUT;
    wire [3:0] DMA_CS = CPU_CS, CHIP_SELECT_N;
    wire [1:0] DMA_BYTE_EN = CPU_BYTE_EN;
    wire [2:0] LATCH_STROBE_PINS;
    wire [7:0] PORT_PINS;
    wire WAIT_REQ_N, CPU_GRANT, DMA_GRANT, CYCLE_DONE, WATCHDOG_RUN, HOLD_GRANT_N, READ_STROBE_N, READ_STROBE_OE_N;
    wire LOW_BYTE_STORE_STROBE_N, HIGH_BYTE_STORE_STROBE_N, STORE_STROBE_OE_N, UPPER_BYTE_ENABLE_N;
    wire UPPER_BYTE_ENABLE_OE_N, ADDR_OE_N, DATA_OE_N, CHIP_SELECT_OE_N, CLOCK_OUT_PIN, CLOCK_OUT_PIN_EN;
    int error_cnt = 0, compares = 0, cycles = 0, low = 0, n, i;
    ext_bus_ctrl ext_bus_ctrl_inst (.*);
    ext_mem_model ext_mem_model_inst (.bus_clk(BUS_CLK), .latch(|LATCH_STROBE_PINS), .rd_n(READ_STROBE_N),
        .wr_n(LOW_BYTE_STORE_STROBE_N & HIGH_BYTE_STORE_STROBE_N), .addr(ADDR_OUT), .stretch(stretch),
        .wait_n(WAIT_REQ_N), .rdata(DATA_IN), .cap(cap));
    // ----
    // Clocks, monitor and tasks
    // ----
    always #20 REF_CLK = ~REF_CLK;
    // The bus clock starts off phase so its edges never line up with the sampling edge.
    initial begin
        #7;
        forever #160 BUS_CLK = ~BUS_CLK;
    end
    always @(negedge REF_CLK) begin
        cycles++;
        if (!READ_STROBE_N || !LOW_BYTE_STORE_STROBE_N) low++;
        if (!LOW_BYTE_STORE_STROBE_N) wseen = DATA_OUT;
        doe |= !DATA_OE_N;
        hseen |= !HIGH_BYTE_STORE_STROBE_N;
        clk_hi |= CLOCK_OUT_PIN;
        seen |= LATCH_STROBE_PINS;
        if (cycles == 5000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h want=%h", $time, got, want);
        end
    endtask
    task automatic complete_run;
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_sig(input int which);
        n = 0;
        while (n < 400 && (which == 0 ? CYCLE_DONE : which == 1 ? CPU_GRANT | DMA_GRANT : !HOLD_GRANT_N) !== 1'b1) begin
            @(negedge REF_CLK);
            n++;
        end
        check(n < 400, 1);
    endtask
    task automatic access(input logic dma, input logic w, input logic in, input logic [23:0] a, input logic [3:0] k);
        @(negedge REF_CLK);
        CPU_WRITE = w;
        CPU_INTERNAL = in;
        CPU_ADDR = a;
        CPU_WDATA = ~a[15:0];
        stretch = k;
        low = 0;
        seen = 3'h0;
        doe = 1'b0;
        hseen = 1'b0;
        DMA_REQ = dma;
        CPU_REQ = !dma;
        wait_sig(0);
        CPU_REQ = 1'b0;
        DMA_REQ = 1'b0;
    endtask
    // ----
    // Tests
    // ----
    initial begin
        repeat (16) @(negedge REF_CLK);
        check({HOLD_GRANT_N, READ_STROBE_N, LATCH_STROBE_PINS}, 5'h18);
        RSTN = 1'b1;
        for (i = 0; i < 16; i++) begin
            {SINGLE_CHIP_MODE, CLOCK_PIN_OUTPUT_SELECT, CLOCK_OUT_FUNCTION_HI, CLOCK_OUT_FUNCTION_LO} = i[3:0];
            @(negedge REF_CLK);
            check(CLOCK_OUT_PIN_EN, i == 0);
            if (i != 0) check(CLOCK_OUT_PIN, 0);
        end
        {SINGLE_CHIP_MODE, CLOCK_PIN_OUTPUT_SELECT, CLOCK_OUT_FUNCTION_HI, CLOCK_OUT_FUNCTION_LO} = 4'h0;
        clk_hi = 1'b0;
        $display("test clock done");
        for (i = 3; i >= 0; i--) begin
            {LATCH_PIN_SELECT_HI, LATCH_PIN_SELECT_LO} = i[1:0];
            access(i[0], 1'b0, 1'b0, 24'h5a0000 + i, i[3:0]);
            check(low, 8 * (1 + i));
            check(READ_DATA, i[15:0] ^ 16'ha5c3);
            check(seen, i == 0 ? 0 : 1 << (i - 1));
            if (i != 0) check(cap, 24'h5a0000 + i);
        end
        SOFT_WAITS = 4'h2;
        {LATCH_PIN_SELECT_HI, LATCH_PIN_SELECT_LO} = 2'h1;
        access(1'b0, 1'b0, 1'b0, 24'h5a0010, 4'h2);
        check(low, 8 * 3);
        SOFT_WAITS = 4'h0;
        CPU_BYTE_EN = 2'h1;
        access(1'b1, 1'b1, 1'b0, 24'h5a1234, 4'h1);
        check(low, 16);
        check(wseen, 16'hedcb);
        check(hseen, 0);
        check(doe, 1);
        check(clk_hi, 1);
        $display("test reads done");
        CPU_BYTE_EN = 2'h3;
        access(1'b0, 1'b1, 1'b1, 24'h000777, 4'h3);
        check(low, 0);
        check(doe, 0);
        check(ADDR_OUT, 24'h5a1234);
        check(UPPER_BYTE_ENABLE_N, 1);
        check(CHIP_SELECT_N, 4'hf);
        check(seen !== 3'h0, 1);
        $display("test internal done");
        @(negedge REF_CLK);
        CPU_REQ = 1'b1;
        DMA_REQ = 1'b1;
        wait_sig(1);
        check({DMA_GRANT, CPU_GRANT}, 2'h2);
        wait_sig(0);
        DMA_REQ = 1'b0;
        repeat (2) @(negedge REF_CLK);
        wait_sig(1);
        check({DMA_GRANT, CPU_GRANT}, 2'h1);
        wait_sig(0);
        CPU_REQ = 1'b0;
        $display("test priority done");
        fork
            access(1'b0, 1'b0, 1'b0, 24'h5a0020, 4'h4);
            begin
                repeat (30) @(negedge REF_CLK);
                BUS_REQ_N = 1'b0;
            end
        join
        check(HOLD_GRANT_N, 1);
        check(READ_DATA, 16'h0020 ^ 16'ha5c3);
        wait_sig(2);
        PORT_OUT_NEXT = 8'hc3;
        CPU_REQ = 1'b1;
        repeat (40) @(negedge REF_CLK);
        check({CPU_GRANT, HOLD_GRANT_N, WATCHDOG_RUN, LATCH_STROBE_PINS, PORT_PINS}, 14'h3c);
        BUS_REQ_N = 1'b1;
        wait_sig(1);
        check(HOLD_GRANT_N, 1);
        wait_sig(0);
        CPU_REQ = 1'b0;
        $display("test hold done");
        complete_run();
    end
endmodule
